// *** pkg/atp_pkg.sv ***
/*
 * Constants shared by the pattern and frame configuration block:
 * register offsets, field positions, write masks, reset values,
 * pattern codes and serial frame sizes.
 * Assumes one 100 MHz clock and a 3-wire serial control port.
 */
package atp_pkg;

    // ****************************************************************
    // Widths and depths
    // ****************************************************************
    localparam int unsigned DATA_W     = 18;
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned HDR_BITS   = 8;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [6:0] REG_INPUT_TYPE = 7'h11;
    localparam logic [6:0] REG_RELOAD     = 7'h13;
    localparam logic [6:0] REG_PAT_LOW    = 7'h14;
    localparam logic [6:0] REG_PAT_MID    = 7'h15;
    localparam logic [6:0] REG_PAT_HIGH   = 7'h16;
    localparam logic [6:0] REG_FRAME_CLK  = 7'h19;

    // ****************************************************************
    // Reset values and writable bits (reserved bits stay zero)
    // ****************************************************************
    localparam logic [7:0] RST_INPUT_TYPE  = 8'h00;
    localparam logic [7:0] RST_RELOAD      = 8'h00;
    localparam logic [7:0] RST_PAT         = 8'h00;
    localparam logic [7:0] RST_FRAME_CLK   = 8'h00;
    localparam logic [7:0] MASK_INPUT_TYPE = 8'h30;
    localparam logic [7:0] MASK_RELOAD     = 8'h01;
    localparam logic [7:0] MASK_PAT        = 8'hFF;
    localparam logic [7:0] MASK_FRAME_CLK  = 8'h91;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned BIT_SE_A       = 5;
    localparam int unsigned BIT_SE_B       = 4;
    localparam int unsigned BIT_RELOAD     = 0;
    localparam int unsigned PAT_B_LSB      = 5;
    localparam int unsigned PAT_A_LSB      = 2;
    localparam int unsigned BIT_FC_SOURCE  = 7;
    localparam int unsigned BIT_FC_DIVIDE  = 4;
    localparam int unsigned BIT_FC_STRETCH = 0;

    // ****************************************************************
    // Test pattern select codes
    // ****************************************************************
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_RAMP   = 3'h2;
    localparam logic [2:0] PAT_CONST  = 3'h3;

endpackage

// *** hdl/atp_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on clk; storage is flip-flops.
 */
module atp_fifo #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } atp_fifo_state_t;

    atp_fifo_state_t q;
    atp_fifo_state_t d;
    logic            push;
    logic            pop;

    // Honest full and empty flags
    assign in_ready  = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + PW'(1);
        end
        if (pop) begin
            d.rp = q.rp + PW'(1);
        end
        d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** hdl/atp_spi_slave.sv ***
/*
 * Serial control port slave: 16-bit frames, read flag, 7-bit
 * address, 8-bit data, most significant bit first.
 * Assumes pins come from outside the clk domain and are synchronised
 * here; read data is returned combinationally by the register file.
 */
module atp_spi_slave (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Serial pins
    input  wire logic       spi_sen_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdio_in,
    output logic            spi_sdio_out,
    output logic            spi_sdio_oe,
    // Register side
    output logic            wr_en,
    output logic      [6:0] reg_addr,
    output logic      [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    typedef struct packed {
        logic [1:0]  sen_s;
        logic [2:0]  sclk_s;
        logic [1:0]  sdi_s;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic [7:0]  rd_sh;
        logic        oe;
        logic        sdo;
        logic        wr;
        logic [6:0]  addr;
        logic [7:0]  wdata;
    } atp_spi_state_t;

    atp_spi_state_t q;
    atp_spi_state_t d;
    logic           rise;
    logic           fall;

    assign spi_sdio_out = q.sdo;
    assign spi_sdio_oe  = q.oe;
    assign wr_en        = q.wr;
    assign reg_addr     = q.addr;
    assign wr_data      = q.wdata;
    // Edges seen from the second and third stages only
    assign rise = q.sclk_s[1] && !q.sclk_s[2];
    assign fall = !q.sclk_s[1] && q.sclk_s[2];

    // Frame shifting, write pulse and read return
    always_comb begin
        d        = q;
        d.wr     = 1'b0;
        d.sen_s  = {q.sen_s[0], spi_sen_n};
        d.sclk_s = {q.sclk_s[1:0], spi_sclk};
        d.sdi_s  = {q.sdi_s[0], spi_sdio_in};
        if (q.sen_s[1]) begin
            d.cnt = 5'h00;
            d.oe  = 1'b0;
        end else begin
            if (rise && q.cnt < 5'(atp_pkg::FRAME_BITS)) begin
                d.sh  = {q.sh[14:0], q.sdi_s[1]};
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == 5'(atp_pkg::HDR_BITS - 1)) begin
                    d.addr = {q.sh[5:0], q.sdi_s[1]};
                end
                if (q.cnt == 5'(atp_pkg::FRAME_BITS - 1) && !q.sh[14]) begin
                    d.wr    = 1'b1;
                    d.wdata = {q.sh[6:0], q.sdi_s[1]};
                end
            end
            if (fall && q.sh[7] && q.cnt == 5'(atp_pkg::HDR_BITS)) begin
                d.oe    = 1'b1;
                d.sdo   = rd_data[7];
                d.rd_sh = {rd_data[6:0], 1'b0};
            end else if (fall && q.oe) begin
                d.sdo   = q.rd_sh[7];
                d.rd_sh = {q.rd_sh[6:0], 1'b0};
            end
        end
    end

    // State register; idle pins read as deselected
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q       <= '0;
            q.sen_s <= 2'h3;
        end else begin
            q <= d;
        end
    end
endmodule

// *** hdl/atp_top.sv ***
/*
 * Pattern insertion and frame clock configuration for a dual channel
 * converter: control registers, test pattern insertion ahead of the
 * bit mapper, sample FIFO and frame clock selection.
 * Assumes samples, frame clock levels and the mapper all run on clk;
 * the serial port pins are asynchronous and are synchronised inside.
 */
// Operation
// - Input type bit 0 means differential, 1 single ended; A bit 5, B bit 4.
// - Mapping reloads only after reload bit written 1 then 0.
// - Reload clears earlier settings; host programs it first.
// - 18-bit pattern over three registers: constant value and ramp step.
// - Constant mode outputs pattern value aligned from the sample MSB.
// - Channel B select bits 7-5: 000 normal, 010 ramp, 011 constant.
// - Channel A select bits 4-2 use the same encoding.
// - Patterns enter before the bit mapper at native resolution.
// - Frame clock source 0 takes the frame clock from the core.
// - Stretch bit 1 makes the frame clock span both channels; here the bit only drives frame_clock_stretch, frame_clock is not stretched.
module atp_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Serial control port
    input  wire logic        spi_sen_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdio_in,
    output logic             spi_sdio_out,
    output logic             spi_sdio_oe,
    // Converter samples, native resolution from the MSB
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire logic [17:0] sample_a,
    input  wire logic [17:0] sample_b,
    // Words towards the bit mapper
    output logic             mapper_valid,
    input  wire logic        mapper_ready,
    output logic      [17:0] mapper_a,
    output logic      [17:0] mapper_b,
    // Input and mapping controls
    output logic             single_ended_chan_a,
    output logic             single_ended_chan_b,
    output logic             mapping_reload,
    // Frame clock
    input  wire logic        core_frame_clock,
    input  wire logic        ddc_frame_clock,
    output logic             frame_clock,
    output logic             frame_clock_source,
    output logic             frame_clock_divide,
    output logic             frame_clock_stretch
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  input_type_select;
        logic [7:0]  mapping_reload_strobe;
        logic [7:0]  pattern_value_low;
        logic [7:0]  pattern_value_mid;
        logic [7:0]  pattern_select_and_high;
        logic [7:0]  frame_clock_config;
        logic        armed;
        logic        reload_pulse;
        logic [17:0] ramp_a;
        logic [17:0] ramp_b;
        logic        frame_clock;
    } atp_state_t;

    atp_state_t  q;
    atp_state_t  d;
    logic        wr_en;
    logic [6:0]  reg_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [17:0] pattern_value;
    logic [2:0]  pattern_select_chan_a;
    logic [2:0]  pattern_select_chan_b;
    logic [17:0] word_a;
    logic [17:0] word_b;
    logic        accept;

    // ****************************************************************
    // Serial port
    // ****************************************************************
    atp_spi_slave u_spi (
        .clk          (clk),
        .nrst         (nrst),
        .spi_sen_n    (spi_sen_n),
        .spi_sclk     (spi_sclk),
        .spi_sdio_in  (spi_sdio_in),
        .spi_sdio_out (spi_sdio_out),
        .spi_sdio_oe  (spi_sdio_oe),
        .wr_en        (wr_en),
        .reg_addr     (reg_addr),
        .wr_data      (wr_data),
        .rd_data      (rd_data)
    );

    // Read back; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            atp_pkg::REG_INPUT_TYPE: rd_data = q.input_type_select;
            atp_pkg::REG_RELOAD:     rd_data = q.mapping_reload_strobe;
            atp_pkg::REG_PAT_LOW:    rd_data = q.pattern_value_low;
            atp_pkg::REG_PAT_MID:    rd_data = q.pattern_value_mid;
            atp_pkg::REG_PAT_HIGH:   rd_data = q.pattern_select_and_high;
            atp_pkg::REG_FRAME_CLK:  rd_data = q.frame_clock_config;
            default:                 rd_data = 8'h00;
        endcase
    end

    // ****************************************************************
    // Register fields
    // ****************************************************************
    assign pattern_value = {q.pattern_select_and_high[1:0],
                            q.pattern_value_mid,
                            q.pattern_value_low};
    assign pattern_select_chan_a =
        q.pattern_select_and_high[atp_pkg::PAT_A_LSB +: 3];
    assign pattern_select_chan_b =
        q.pattern_select_and_high[atp_pkg::PAT_B_LSB +: 3];
    assign single_ended_chan_a =
        q.input_type_select[atp_pkg::BIT_SE_A];
    assign single_ended_chan_b =
        q.input_type_select[atp_pkg::BIT_SE_B];
    assign mapping_reload      = q.reload_pulse;
    assign frame_clock_source  = q.frame_clock_config[atp_pkg::BIT_FC_SOURCE];
    assign frame_clock_divide  = q.frame_clock_config[atp_pkg::BIT_FC_DIVIDE];
    assign frame_clock_stretch =
        q.frame_clock_config[atp_pkg::BIT_FC_STRETCH];
    assign frame_clock         = q.frame_clock;

    // ****************************************************************
    // Pattern insertion ahead of the bit mapper
    // ****************************************************************
    // Ramp, constant from the MSB, or the converter word; unused codes pass
    always_comb begin
        unique case (pattern_select_chan_a)
            atp_pkg::PAT_RAMP:  word_a = q.ramp_a;
            atp_pkg::PAT_CONST: word_a = pattern_value;
            default:            word_a = sample_a;
        endcase
        unique case (pattern_select_chan_b)
            atp_pkg::PAT_RAMP:  word_b = q.ramp_b;
            atp_pkg::PAT_CONST: word_b = pattern_value;
            default:            word_b = sample_b;
        endcase
    end

    // FIFO back-pressure stalls the converter side
    assign accept = sample_valid && sample_ready;

    atp_fifo #(
        .WIDTH (2 * atp_pkg::DATA_W),
        .DEPTH (atp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   ({word_a, word_b}),
        .out_valid (mapper_valid),
        .out_ready (mapper_ready),
        .out_data  ({mapper_a, mapper_b})
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d              = q;
        d.reload_pulse = 1'b0;
        // Ramps step by the pattern value per accepted sample
        if (pattern_select_chan_a != atp_pkg::PAT_RAMP) begin
            d.ramp_a = 18'h00000;
        end else if (accept) begin
            d.ramp_a = q.ramp_a + pattern_value;
        end
        if (pattern_select_chan_b != atp_pkg::PAT_RAMP) begin
            d.ramp_b = 18'h00000;
        end else if (accept) begin
            d.ramp_b = q.ramp_b + pattern_value;
        end
        // Frame clock from the core unless the source bit picks the DDC
        d.frame_clock = frame_clock_source ? ddc_frame_clock
                                           : core_frame_clock;
        // Register writes, reserved bits masked to zero
        if (wr_en) begin
            unique case (reg_addr)
                atp_pkg::REG_INPUT_TYPE: begin
                    d.input_type_select =
                        wr_data & atp_pkg::MASK_INPUT_TYPE;
                end
                atp_pkg::REG_RELOAD: begin
                    d.mapping_reload_strobe =
                        wr_data & atp_pkg::MASK_RELOAD;
                end
                atp_pkg::REG_PAT_LOW: begin
                    d.pattern_value_low = wr_data & atp_pkg::MASK_PAT;
                end
                atp_pkg::REG_PAT_MID: begin
                    d.pattern_value_mid = wr_data & atp_pkg::MASK_PAT;
                end
                atp_pkg::REG_PAT_HIGH: begin
                    d.pattern_select_and_high = wr_data & atp_pkg::MASK_PAT;
                end
                atp_pkg::REG_FRAME_CLK: begin
                    d.frame_clock_config =
                        wr_data & atp_pkg::MASK_FRAME_CLK;
                end
                default: begin
                end
            endcase
        end
        // Reload fires when a set bit is written back to zero
        if (wr_en && reg_addr == atp_pkg::REG_RELOAD) begin
            if (wr_data[atp_pkg::BIT_RELOAD]) begin
                d.armed = 1'b1;
            end else if (q.armed) begin
                d.armed        = 1'b0;
                d.reload_pulse = 1'b1;
                // Reload wipes all earlier configuration writes
                d.input_type_select       = atp_pkg::RST_INPUT_TYPE;
                d.pattern_value_low       = atp_pkg::RST_PAT;
                d.pattern_value_mid       = atp_pkg::RST_PAT;
                d.pattern_select_and_high = atp_pkg::RST_PAT;
                d.frame_clock_config      = atp_pkg::RST_FRAME_CLK;
                d.ramp_a                  = 18'h00000;
                d.ramp_b                  = 18'h00000;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q                         <= '0;
            q.input_type_select       <= atp_pkg::RST_INPUT_TYPE;
            q.mapping_reload_strobe   <= atp_pkg::RST_RELOAD;
            q.pattern_value_low       <= atp_pkg::RST_PAT;
            q.pattern_value_mid       <= atp_pkg::RST_PAT;
            q.pattern_select_and_high <= atp_pkg::RST_PAT;
            q.frame_clock_config      <= atp_pkg::RST_FRAME_CLK;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_se_chan_a:
    assert property (@(posedge clk) disable iff (!nrst)
        wr_en && reg_addr == atp_pkg::REG_INPUT_TYPE
        && wr_data[atp_pkg::BIT_SE_A] |=> single_ended_chan_a)
        else $error("channel A single ended not taken");

    a_reload_cause:
    assert property (@(posedge clk) disable iff (!nrst)
        mapping_reload |-> $past(wr_en) && $past(q.armed)
        && $past(reg_addr) == atp_pkg::REG_RELOAD && !$past(wr_data[0]))
        else $error("reload without a one then zero write");

    a_reload_wipes:
    assert property (@(posedge clk) disable iff (!nrst)
        mapping_reload |-> pattern_value == 18'h00000
        && q.frame_clock_config == 8'h00
        && q.input_type_select == 8'h00)
        else $error("reload left configuration in place");

    a_ramp_step:
    assert property (@(posedge clk) disable iff (!nrst)
        accept && !wr_en && pattern_select_chan_a == atp_pkg::PAT_RAMP
        |=> q.ramp_a == $past(q.ramp_a) + $past(pattern_value))
        else $error("ramp did not advance by the step");

    a_const_word:
    assert property (@(posedge clk) disable iff (!nrst)
        pattern_select_chan_b == atp_pkg::PAT_CONST
        |-> word_b == pattern_value)
        else $error("constant pattern not on channel B");

    a_normal_pass:
    assert property (@(posedge clk) disable iff (!nrst)
        pattern_select_chan_a == atp_pkg::PAT_NORMAL |-> word_a == sample_a)
        else $error("normal mode does not pass samples");

    a_source_core:
    assert property (@(posedge clk) disable iff (!nrst)
        !frame_clock_source && !wr_en
        |=> frame_clock == $past(core_frame_clock))
        else $error("frame clock not from core");

    a_stretch_set:
    assert property (@(posedge clk) disable iff (!nrst)
        wr_en && reg_addr == atp_pkg::REG_FRAME_CLK && wr_data[0]
        ##1 !mapping_reload |-> frame_clock_stretch)
        else $error("stretch bit not applied");

    a_reserved_zero:
    assert property (@(posedge clk) disable iff (!nrst)
        (q.input_type_select & ~atp_pkg::MASK_INPUT_TYPE) == 8'h00
        && (q.frame_clock_config & ~atp_pkg::MASK_FRAME_CLK) == 8'h00)
        else $error("reserved bits not held at zero");
endmodule

// *** testbench/atp_host_model.sv ***
/* Host model on the serial control port: sends 16-bit frames.
   Assumes the bench calls frame() and clk is the block clock. */
module atp_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      spi_sen_n,
    output logic      spi_sclk,
    output logic      spi_sdio_in,
    input  wire logic spi_sdio_out,
    input  wire logic spi_sdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hd = 1'h0;
    logic hoe = 1'h0;
    // Shared data wire; a released line shows the inverse of the last bit
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (hoe ? hd : ~hd);
    // Idle: deselected, clock stands low
    initial begin
        spi_sen_n = 1'h1;
        spi_sclk = 1'h0;
    end
    // One frame, MSB first, 6 clk per phase; q gets read data
    task automatic frame(input logic [15:0] w, output logic [7:0] q);
        q = 8'h00;
        @(posedge clk) spi_sen_n <= 1'h0;
        for (int i = 15; i >= 0; i--) begin
            repeat (6) @(posedge clk);
            spi_sclk <= 1'h0;
            hd <= w[i];
            hoe <= !(w[15] && i < 8);
            repeat (6) @(posedge clk);
            spi_sclk <= 1'h1;
            if (!hoe) q[i] = spi_sdio_in;
        end
        repeat (6) @(posedge clk);
        spi_sen_n <= 1'h1;
        hoe <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// *** testbench/adc_test_pattern_frame_config_tb_top.sv ***
/* Self-checking bench: registers over the serial port, random samples
   and frame clocks. Assumes the package and design are compiled. */
module adc_test_pattern_frame_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, nrst = 1'h0, sen_n, sclk, sdi, sdo, sdo_oe;
    logic s_vld = 1'h0, m_rdy = 1'h0, s_rdy, m_vld, rld, fc, exp_fc;
    logic core_fc = 1'h0, ddc_fc = 1'h0, se_a, se_b, src_o, div_o, str_o;
    logic [17:0] s_a = 18'h0, s_b = 18'h0, m_a, m_b, pv = 18'h0, ra, rb;
    logic [2:0] sel_a = 3'h0, sel_b = 3'h0;
    logic [7:0] q, d;
    logic [35:0] sb[$];
    logic [6:0] regs[7] = '{7'h11, 7'h13, 7'h14, 7'h15, 7'h16, 7'h19, 7'h12};
    logic [7:0] fcv[5] = '{8'h10, 8'h00, 8'h80, 8'h01, 8'hFF};
    logic [23:0] cv[6] = '{{6'h1A, 18'h4}, {6'h13, 18'h10}, {6'h1B, 18'h2D4B7},
                           {6'h12, 18'h1}, {6'h29, 18'h1}, {6'h00, 18'h0}};
    int seed = 93, error_cnt = 0, compares = 0, cyc = 0, n_rld = 0;
    bit fc_on = 0, src = 0, rnd = 0;
    // ****************************************************************
    // Design, host model, clock and checks
    // ****************************************************************
    atp_top u_dut (.clk(clk), .nrst(nrst), .spi_sen_n(sen_n),
        .spi_sclk(sclk), .spi_sdio_in(sdi), .spi_sdio_out(sdo),
        .spi_sdio_oe(sdo_oe), .sample_valid(s_vld), .sample_ready(s_rdy),
        .sample_a(s_a), .sample_b(s_b), .mapper_valid(m_vld),
        .mapper_ready(m_rdy), .mapper_a(m_a), .mapper_b(m_b),
        .single_ended_chan_a(se_a), .single_ended_chan_b(se_b),
        .mapping_reload(rld), .core_frame_clock(core_fc),
        .ddc_frame_clock(ddc_fc), .frame_clock(fc),
        .frame_clock_source(src_o), .frame_clock_divide(div_o),
        .frame_clock_stretch(str_o));
    atp_host_model u_host (.clk(clk), .spi_sen_n(sen_n), .spi_sclk(sclk),
        .spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(sdo_oe));
    always #5 clk = ~clk;
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        u_host.frame({1'h0, a, v}, q);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        u_host.frame({1'h1, a, 8'h00}, q);
        check(36'(q), 36'(e));
    endtask
    // Expected word of one channel; the ramp steps per accepted sample
    function automatic logic [17:0] pat(input logic [2:0] s,
                                        input logic [17:0] smp,
                                        inout logic [17:0] r);
        pat = (s == atp_pkg::PAT_CONST) ? pv :
              (s == atp_pkg::PAT_RAMP) ? r : smp;
        r = (s == atp_pkg::PAT_RAMP) ? r + pv : 18'h0;
    endfunction
    // Random samples and frame clock levels
    always @(posedge clk) begin
        core_fc <= 1'($random(seed));
        ddc_fc <= 1'($random(seed));
        s_a <= 18'($random(seed));
        s_b <= 18'($random(seed));
        if (rnd) begin
            s_vld <= 1'($random(seed));
            m_rdy <= 1'($random(seed));
        end
    end
    // Scoreboard, reload pulses, frame clock and timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc > 30000) begin
            error_cnt++;
            complete_run();
        end
        if (rld) n_rld++;
        if (fc_on) check(36'(fc), 36'(exp_fc));
        exp_fc = src ? ddc_fc : core_fc;
        if (s_vld && s_rdy) sb.push_back({pat(sel_a, s_a, ra),
                                          pat(sel_b, s_b, rb)});
        if (m_vld && m_rdy)
            check({m_a, m_b}, sb.pop_front());
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        repeat (4) @(posedge clk);
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        wr(7'h11, 8'h30);
        wr(7'h13, 8'h00);
        wr(7'h13, 8'h01);
        check(36'(n_rld), 36'h0);
        wr(7'h13, 8'h00);
        check(36'(n_rld), 36'h1);
        rd_chk(7'h11, 8'h00);
        repeat (4) begin
            d = 8'($random(seed));
            wr(7'h11, d);
            rd_chk(7'h11, d & 8'h30);
            check({se_a, se_b}, {d[5], d[4]});
        end
        foreach (fcv[i]) begin
            fc_on = 0;
            wr(7'h19, fcv[i]);
            @(negedge clk) src = fcv[i][7];
            @(negedge clk) fc_on = 1;
            repeat (20) @(posedge clk);
            rd_chk(7'h19, fcv[i] & 8'h91);
            check(36'({src_o, div_o, str_o}),
                  36'({fcv[i][7], fcv[i][4], fcv[i][0]}));
        end
        fc_on = 0;
        @(posedge clk) s_vld <= 1'h1;
        repeat (12) @(posedge clk);
        s_vld <= 1'h0;
        @(negedge clk) check(36'(sb.size()), 36'h8);
        check(36'(s_rdy), 36'h0);
        @(posedge clk) m_rdy <= 1'h1;
        repeat (12) @(posedge clk);
        @(negedge clk) check(36'(m_vld), 36'h0);
        foreach (cv[i]) begin
            wr(7'h14, cv[i][7:0]);
            wr(7'h15, cv[i][15:8]);
            wr(7'h16, {cv[i][23:18], cv[i][17:16]});
            @(negedge clk) {sel_b, sel_a, pv} = cv[i];
            ra = 18'h0;
            rb = 18'h0;
            rnd = 1;
            repeat (80) @(posedge clk);
            @(negedge clk) rnd = 0;
            @(posedge clk) s_vld <= 1'h0;
            m_rdy <= 1'h1;
            repeat (12) @(posedge clk);
        end
        check(36'(sb.size()), 36'h0);
        complete_run();
    end
endmodule
